/* File: chain_loader_dev.sv */
// Device end: loads its configuration and hands off along the chain
`timescale 1ns/1ps
`include "chain_regs.svh"
module chain_loader_dev (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // Link
   chain_link_if.dev                  link,
   // Mode select, held stable while loading
   input  wire chain_pkg::load_mode_e mode,
   // Loaded data
   output logic [7:0]                 cfg_byte,
   output logic                       cfg_byte_valid,
   // Status
   output logic                       load_active,
   output logic                       user_mode
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   chain_pkg::dev_state_e state_r;
   chain_pkg::dev_state_e state_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [7:0]  byte_r;
   logic [7:0]  byte_nxt;
   logic [2:0]  bitn_r;
   logic [2:0]  bitn_nxt;
   logic [7:0]  init_r;
   logic [7:0]  init_nxt;
   logic        ceo_n_r;
   logic        ceo_n_nxt;
   logic [7:0]  out_r;
   logic [7:0]  out_nxt;
   logic        vld_r;
   logic        vld_nxt;
   logic        stat_low_r;
   logic        dclk_q_r;
   logic        tck_q_r;
   logic        tdo_r;
   logic        tdo_nxt;

   // ----------------------------------------------------------------
   // Edge detection on the link clocks
   // ----------------------------------------------------------------
   logic        dclk_rise;
   logic        tck_rise;
   logic        load_data_bit0;
   logic        ser_take;
   logic        par_take;
   logic        ser_bit;
   logic [15:0] cnt_step;

   assign dclk_rise      = link.dclk & ~dclk_q_r;
   assign tck_rise       = link.tck & ~tck_q_r;
   assign load_data_bit0 = link.load_data[0];

   always_comb begin
      ser_take = 1'b0;
      par_take = 1'b0;
      ser_bit  = 1'b0;
      case (mode)
         chain_pkg::MODE_PASSIVE_SERIAL: begin
            ser_take = dclk_rise & ~link.ce_n;
            ser_bit  = load_data_bit0;
         end
         chain_pkg::MODE_FAST_PARALLEL: begin
            // Only this mode looks at bits 1 to 7
            par_take = dclk_rise & ~link.ce_n;
         end
         chain_pkg::MODE_SCAN: begin
            // A high enable mid-load freezes the scan load
            ser_take = tck_rise & link.scan_load & ~link.ce_n;
            ser_bit  = link.tdi;
         end
         default: begin
            ser_take = 1'b0;
            par_take = 1'b0;
         end
      endcase
   end

   assign cnt_step = par_take ? `PAR_STEP :
                     (ser_take ? `SER_STEP : 16'h0000);

   // ----------------------------------------------------------------
   // Load sequence
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      byte_nxt  = byte_r;
      bitn_nxt  = bitn_r;
      init_nxt  = init_r;
      ceo_n_nxt = ceo_n_r;
      out_nxt   = out_r;
      vld_nxt   = 1'b0;
      case (state_r)
         chain_pkg::ST_WAIT: begin
            ceo_n_nxt = 1'b1;
            // Start only when enabled and nobody holds status low
            if (!link.ce_n && link.cfg_status) begin
               state_nxt = chain_pkg::ST_LOAD;
               cnt_nxt   = 16'h0000;
               bitn_nxt  = 3'h0;
            end
         end
         chain_pkg::ST_LOAD: begin
            ceo_n_nxt = 1'b1;
            if (ser_take) begin
               byte_nxt = {ser_bit, byte_r[7:1]};
               bitn_nxt = bitn_r + 3'h1;
               if (bitn_r == `BYTE_LAST) begin
                  out_nxt = {ser_bit, byte_r[7:1]};
                  vld_nxt = 1'b1;
               end
            end
            if (par_take) begin
               out_nxt = link.load_data;
               vld_nxt = 1'b1;
            end
            cnt_nxt = cnt_r + cnt_step;
            if (cnt_nxt >= `CFG_BITS) begin
               state_nxt = chain_pkg::ST_DONE;
               // Handoff and line release fall in the same cycle
               ceo_n_nxt = 1'b0;
            end
         end
         chain_pkg::ST_DONE: begin
            // Hand the chain on; in scan mode only a high scan load gets here
            ceo_n_nxt = 1'b0;
            // Shared completion line rises only when all have finished
            if (link.load_complete) begin
               state_nxt = chain_pkg::ST_INIT;
               init_nxt  = 8'h00;
            end
         end
         chain_pkg::ST_INIT: begin
            ceo_n_nxt = 1'b0;
            init_nxt  = init_r + 8'h01;
            if (init_r == `INIT_CYCLES - 8'h01) begin
               state_nxt = chain_pkg::ST_USER;
            end
         end
         chain_pkg::ST_USER: begin
            ceo_n_nxt = 1'b0;
         end
         default: begin
            state_nxt = chain_pkg::ST_WAIT;
            ceo_n_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= chain_pkg::ST_WAIT;
         cnt_r   <= 16'h0000;
         byte_r  <= 8'h00;
         bitn_r  <= 3'h0;
         init_r  <= 8'h00;
         ceo_n_r <= 1'b1;
         out_r   <= 8'h00;
         vld_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         byte_r  <= byte_nxt;
         bitn_r  <= bitn_nxt;
         init_r  <= init_nxt;
         ceo_n_r <= ceo_n_nxt;
         out_r   <= out_nxt;
         vld_r   <= vld_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Test data path
   // ----------------------------------------------------------------
   // One stage per device, so chain length adds only latency
   always_comb begin
      tdo_nxt = tck_rise ? link.tdi : tdo_r;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tdo_r      <= 1'b0;
         dclk_q_r   <= 1'b0;
         tck_q_r    <= 1'b0;
         stat_low_r <= 1'b1;
      end else begin
         tdo_r      <= tdo_nxt;
         dclk_q_r   <= link.dclk;
         tck_q_r    <= link.tck;
         stat_low_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Link drive
   // ----------------------------------------------------------------
   // Completion is held low until this device has its full stream
   assign link.load_complete_o  = 1'b0;
   assign link.load_complete_oe = (state_r == chain_pkg::ST_WAIT) ||
                                  (state_r == chain_pkg::ST_LOAD);
   // Status pulled low through the reset cycle only
   assign link.cfg_status_o     = 1'b0;
   assign link.cfg_status_oe    = stat_low_r;
   assign link.ceo_n            = ceo_n_r;
   assign link.tdo              = tdo_r;

   // ----------------------------------------------------------------
   // User side
   // ----------------------------------------------------------------
   assign cfg_byte       = out_r;
   assign cfg_byte_valid = vld_r;
   assign load_active    = (state_r == chain_pkg::ST_LOAD);
   assign user_mode      = (state_r == chain_pkg::ST_USER);

endmodule

/* File: chain_regs.svh */
// Timing and size constants for the configuration chain handoff
`ifndef CHAIN_REGS_SVH
`define CHAIN_REGS_SVH

// ----------------------------------------------------------------
// Load sizes
// ----------------------------------------------------------------
`define CFG_BITS     16'h0040
`define BYTE_LAST    3'h7
`define PAR_STEP     16'h0008
`define SER_STEP     16'h0001

// ----------------------------------------------------------------
// Timing counts in clk cycles
// ----------------------------------------------------------------
`define INIT_CYCLES  8'h08
`define LINK_HALF    4'h4

`endif

/* File: chain_pkg.sv */
// Types shared by both ends of the configuration chain handoff
package chain_pkg;

   // ----------------------------------------------------------------
   // Load modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_PASSIVE_SERIAL = 2'b00,
      MODE_FAST_PARALLEL  = 2'b01,
      MODE_SCAN           = 2'b10
   } load_mode_e;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_WAIT = 3'b000,
      ST_LOAD = 3'b001,
      ST_DONE = 3'b010,
      ST_INIT = 3'b011,
      ST_USER = 3'b100
   } dev_state_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_RUN  = 2'b01,
      H_WAIT = 2'b10
   } host_state_e;

endpackage

/* File: chain_link_if.sv */
// Link between a chained loading device and its loading host
`timescale 1ns/1ps
interface chain_link_if;
   // Chain enable, active low
   logic       ce_n;
   logic       ceo_n;
   // Open-drain completion and status lines with pull-up
   logic       load_complete_o;
   logic       load_complete_oe;
   logic       load_complete;
   logic       cfg_status_o;
   logic       cfg_status_oe;
   logic       cfg_status;
   // Load clock and data
   logic       dclk;
   logic [7:0] load_data;
   // Boundary-scan
   logic       tck;
   logic       tdi;
   logic       tdo;
   logic       scan_load;
   logic       scan_bypass;

   // Pull-up wins unless a driver pulls low
   assign load_complete = ~(load_complete_oe & ~load_complete_o);
   assign cfg_status    = ~(cfg_status_oe & ~cfg_status_o);

   modport dev (
      input  ce_n, load_complete, cfg_status, dclk, load_data,
      input  tck, tdi, scan_load, scan_bypass,
      output ceo_n, load_complete_o, load_complete_oe,
      output cfg_status_o, cfg_status_oe, tdo
   );

   modport host (
      output ce_n, dclk, load_data, tck, tdi, scan_load, scan_bypass,
      input  ceo_n, load_complete, cfg_status, tdo
   );
endinterface

/* File: chain_loader_host.sv */
// Host end: drives the load clock, data and chain enable of a device
`timescale 1ns/1ps
`include "chain_regs.svh"
module chain_loader_host (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // Link
   chain_link_if.host                 link,
   // Command
   input  wire logic                  start,
   input  wire chain_pkg::load_mode_e mode,
   input  wire logic                  bypass_en,
   // Byte stream
   input  wire logic [7:0]            in_byte,
   input  wire logic                  in_valid,
   output logic                       in_ready,
   // Status
   output logic                       busy,
   output logic                       finished,
   output logic                       tdo_seen
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   chain_pkg::host_state_e state_r, state_nxt;
   chain_pkg::load_mode_e  mode_r, mode_nxt;
   logic [3:0]  div_r, div_nxt;
   logic        lclk_r, lclk_nxt;
   logic        have_r, have_nxt;
   logic [15:0] sent_r, sent_nxt;
   logic [7:0]  sh_r, sh_nxt;
   logic [7:0]  data_r, data_nxt;
   logic [2:0]  bitn_r, bitn_nxt;
   logic        ce_n_r, ce_n_nxt;
   logic        byp_r, byp_nxt;
   logic        fin_r, fin_nxt;
   logic        tdo_r, tdo_nxt;
   logic        par_mode;
   logic        need_byte;

   assign par_mode  = (mode_r == chain_pkg::MODE_FAST_PARALLEL);
   assign need_byte = par_mode || (bitn_r == 3'h0);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      mode_nxt  = mode_r;
      div_nxt   = div_r;
      lclk_nxt  = lclk_r;
      have_nxt  = have_r;
      sent_nxt  = sent_r;
      sh_nxt    = sh_r;
      data_nxt  = data_r;
      bitn_nxt  = bitn_r;
      ce_n_nxt  = ce_n_r;
      byp_nxt   = byp_r;
      fin_nxt   = fin_r;
      tdo_nxt   = tdo_r;
      in_ready  = 1'b0;
      case (state_r)
         chain_pkg::H_IDLE: begin
            if (start) begin
               state_nxt = chain_pkg::H_RUN;
               mode_nxt  = mode;
               byp_nxt   = bypass_en;
               // First device enable held low for the whole load
               ce_n_nxt  = 1'b0;
               fin_nxt   = 1'b0;
               sent_nxt  = 16'h0000;
               bitn_nxt  = 3'h0;
               div_nxt   = 4'h0;
               have_nxt  = 1'b0;
               lclk_nxt  = 1'b0;
            end
         end
         chain_pkg::H_RUN: begin
            // Low phase: present the next bit or byte, stall if none
            if (!lclk_r && !have_r) begin
               if (need_byte) begin
                  in_ready = 1'b1;
                  if (in_valid) begin
                     data_nxt = in_byte;
                     sh_nxt   = {1'b0, in_byte[7:1]};
                     bitn_nxt = par_mode ? 3'h0 : 3'h1;
                     have_nxt = 1'b1;
                  end
               end else begin
                  data_nxt = {7'h00, sh_r[0]};
                  sh_nxt   = {1'b0, sh_r[7:1]};
                  bitn_nxt = bitn_r + 3'h1;
                  have_nxt = 1'b1;
               end
            end
            if (div_r == `LINK_HALF - 4'h1) begin
               div_nxt = 4'h0;
               if (lclk_r) begin
                  lclk_nxt = 1'b0;
               end else if (have_r) begin
                  lclk_nxt = 1'b1;
                  have_nxt = 1'b0;
                  tdo_nxt  = link.tdo;
                  sent_nxt = sent_r + (par_mode ? `PAR_STEP : `SER_STEP);
               end
            end else begin
               div_nxt = div_r + 4'h1;
            end
            // Whole device stream is sent, never a subset
            if (!lclk_r && sent_r >= `CFG_BITS) begin
               state_nxt = byp_r ? chain_pkg::H_IDLE : chain_pkg::H_WAIT;
               fin_nxt   = byp_r;
            end
         end
         chain_pkg::H_WAIT: begin
            if (link.load_complete) begin
               state_nxt = chain_pkg::H_IDLE;
               fin_nxt   = 1'b1;
            end
         end
         default: state_nxt = chain_pkg::H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= chain_pkg::H_IDLE;
         mode_r  <= chain_pkg::MODE_PASSIVE_SERIAL;
         div_r   <= 4'h0;
         lclk_r  <= 1'b0;
         have_r  <= 1'b0;
         sent_r  <= 16'h0000;
         sh_r    <= 8'h00;
         data_r  <= 8'h00;
         bitn_r  <= 3'h0;
         ce_n_r  <= 1'b1;
         byp_r   <= 1'b0;
         fin_r   <= 1'b0;
         tdo_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         mode_r  <= mode_nxt;
         div_r   <= div_nxt;
         lclk_r  <= lclk_nxt;
         have_r  <= have_nxt;
         sent_r  <= sent_nxt;
         sh_r    <= sh_nxt;
         data_r  <= data_nxt;
         bitn_r  <= bitn_nxt;
         ce_n_r  <= ce_n_nxt;
         byp_r   <= byp_nxt;
         fin_r   <= fin_nxt;
         tdo_r   <= tdo_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Link drive
   // ----------------------------------------------------------------
   assign link.ce_n        = ce_n_r;
   assign link.dclk        = (mode_r != chain_pkg::MODE_SCAN) & lclk_r;
   assign link.tck         = (mode_r == chain_pkg::MODE_SCAN) & lclk_r;
   assign link.load_data   = data_r;
   assign link.tdi         = data_r[0];
   assign link.scan_load   = (mode_r == chain_pkg::MODE_SCAN) & ~byp_r &
                             (state_r == chain_pkg::H_RUN);
   assign link.scan_bypass = byp_r;
   assign busy             = (state_r != chain_pkg::H_IDLE);
   assign finished         = fin_r;
   assign tdo_seen         = tdo_r;

endmodule

/* File: chain_link_assertions.sv */
// Concurrent checks on the link between a loading host and a device
`timescale 1ns/1ps
module chain_link_assertions (
   // Clock and reset
   input wire logic       clk,
   input wire logic       srst,
   // Chain enable and open-drain lines
   input wire logic       ce_n,
   input wire logic       ceo_n,
   input wire logic       load_complete_oe,
   input wire logic       load_complete,
   input wire logic       cfg_status,
   // Load and scan lines
   input wire logic       dclk,
   input wire logic [7:0] load_data,
   input wire logic       tck,
   input wire logic       tdi,
   input wire logic       tdo
);
   // ----------------------------------------------------------------
   // Clocking
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // ----------------------------------------------------------------
   // Chain enable handoff
   // ----------------------------------------------------------------
   a_ceo_idle_high: assert property (ce_n |-> ceo_n)
      else $error("chain-enable output low while input inactive");
   a_ceo_stays_low: assert property (!ceo_n |=> !ceo_n)
      else $error("chain-enable output rose again before reset");
   a_ceo_needs_enable: assert property ($fell(ceo_n) |-> !$past(ce_n))
      else $error("chain-enable output fell without enable");
   a_done_frees_line: assert property (
      $fell(ceo_n) |-> !load_complete_oe && load_complete)
      else $error("completion line not released at handoff");
   a_release_with_ceo: assert property (
      $fell(load_complete_oe) |-> ##[0:1] !ceo_n)
      else $error("completion released without chain handoff");

   // ----------------------------------------------------------------
   // Shared completion and status lines
   // ----------------------------------------------------------------
   // A device that has not handed off keeps every device out of user mode
   a_hold_until_done: assert property (
      ceo_n |-> load_complete_oe && !load_complete)
      else $error("completion line free before load finished");
   a_status_freed: assert property (
      !$past(srst) && !$past(srst, 2) |-> cfg_status)
      else $error("status line still held after reset");

   // ----------------------------------------------------------------
   // Link clocks and bypass stage
   // ----------------------------------------------------------------
   a_dclk_half: assert property ($rose(dclk) |-> dclk[*4] ##1 !dclk)
      else $error("load clock high phase not four cycles");
   a_data_steady: assert property (
      dclk && $past(dclk) |-> $stable(load_data))
      else $error("load data moved while load clock high");
   a_bypass_stage: assert property ($rose(tck) |=> tdo == $past(tdi))
      else $error("bypass output did not take scan input");
   a_tdo_holds: assert property (!$rose(tck) |=> $stable(tdo))
      else $error("bypass output moved without scan clock");
endmodule

/* File: testbench.sv */
// Self-checking bench joining a loading host to a chained device
`timescale 1ns/1ps
`define CHECK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin \
   n_fail++; $display("wrong value at %0t: %s", $time, m); end end
module testbench;
   typedef struct {
      chain_pkg::load_mode_e m;
      logic                  byp;
      logic [7:0]            base;
      logic                  exp_user;
   } row_s;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic                  clk;
   logic                  srst;
   logic                  start;
   logic                  bypass_en;
   logic                  in_valid;
   logic                  in_ready;
   logic                  busy;
   logic                  finished;
   logic                  tdo_seen;
   logic                  cfg_byte_valid;
   logic                  load_active;
   logic                  user_mode;
   logic [7:0]            in_byte;
   logic [7:0]            cfg_byte;
   chain_pkg::load_mode_e mode;
   int                    n_fail = 0;
   int                    cmp_count = 0;
   logic [7:0]            got[$];
   row_s                  rows[4] = '{
      '{chain_pkg::MODE_PASSIVE_SERIAL, 1'b0, 8'h01, 1'b1},
      '{chain_pkg::MODE_FAST_PARALLEL,  1'b0, 8'hA5, 1'b1},
      '{chain_pkg::MODE_SCAN,           1'b0, 8'h3C, 1'b1},
      '{chain_pkg::MODE_SCAN,           1'b1, 8'h5A, 1'b0}};

   // ----------------------------------------------------------------
   // Ends of the link and checker
   // ----------------------------------------------------------------
   chain_link_if link ();
   chain_loader_host chain_loader_host_i (
      .clk(clk), .srst(srst), .link(link), .start(start), .mode(mode),
      .bypass_en(bypass_en), .in_byte(in_byte), .in_valid(in_valid),
      .in_ready(in_ready), .busy(busy), .finished(finished),
      .tdo_seen(tdo_seen));
   chain_loader_dev chain_loader_dev_i (
      .clk(clk), .srst(srst), .link(link), .mode(mode),
      .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
      .load_active(load_active), .user_mode(user_mode));
   chain_link_assertions chain_link_assertions_i (
      .clk(clk), .srst(srst), .ce_n(link.ce_n), .ceo_n(link.ceo_n),
      .load_complete_oe(link.load_complete_oe),
      .load_complete(link.load_complete), .cfg_status(link.cfg_status),
      .dclk(link.dclk), .load_data(link.load_data), .tck(link.tck),
      .tdi(link.tdi), .tdo(link.tdo));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Valid stands a whole cycle, so the falling edge sees it once, settled
   always @(negedge clk) begin
      if (cfg_byte_valid === 1'b1) got.push_back(cfg_byte);
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   function automatic logic [7:0] pat(input logic [7:0] b, input int k);
      return b + 8'(k) * 8'h25;
   endfunction

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic do_reset;
      srst = 1'b1;
      start = 1'b0;
      in_valid = 1'b0;
      repeat (8) @(negedge clk);
      `CHECK({link.ceo_n, link.load_complete}, 2'b10, "reset line")
      `CHECK({user_mode, busy, load_active}, 3'b000, "reset state")
      srst = 1'b0;
      got.delete();
   endtask

   // Valid is held up between bytes so it is never written twice at once
   task automatic send_byte(input logic [7:0] b, input logic last);
      int w;
      in_byte = b;
      in_valid = 1'b1;
      for (w = 0; w < 200 && in_ready !== 1'b1; w++) @(negedge clk);
      `CHECK(in_ready, 1'b1, "host never took a byte")
      @(negedge clk);
      if (last) in_valid = 1'b0;
   endtask

   task automatic run_load(input row_s r, input logic stall);
      int k;
      logic [7:0] lastb;
      do_reset();
      mode = r.m;
      bypass_en = r.byp;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (k = 0; k < 8; k++) begin
         send_byte(pat(r.base, k), k == 7 || (stall && k == 3));
         if (stall && k == 3) begin
            for (int w = 0; w < 200 && in_ready !== 1'b1; w++) @(negedge clk);
            // A second start while busy must change nothing
            start = 1'b1;
            repeat (12) begin
               @(negedge clk);
               start = 1'b0;
               `CHECK(link.dclk, 1'b0, "load clock ran while stalled")
            end
         end
      end
      if (r.exp_user) begin
         for (k = 0; k < 300 && link.ceo_n !== 1'b0; k++) @(negedge clk);
         `CHECK(user_mode, 1'b0, "user mode before completion")
      end
      for (k = 0; k < 300 && finished !== 1'b1; k++) @(negedge clk);
      `CHECK({finished, busy}, 2'b10, "host did not finish")
      repeat (12) @(negedge clk);
      `CHECK({link.ceo_n, load_active}, {2{~r.exp_user}}, "handoff")
      `CHECK(user_mode, r.exp_user, "user mode")
      if (r.exp_user) begin
         `CHECK(got.size(), 8, "loaded byte count")
         for (k = 0; k < got.size(); k++)
            `CHECK(got[k], pat(r.base, k), "loaded byte")
      end
      // Host sees at the last rise the bit before it, one stage behind
      lastb = pat(r.base, 7);
      if (r.m == chain_pkg::MODE_SCAN)
         `CHECK(tdo_seen, lastb[6], "bypass stage")
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      mode = chain_pkg::MODE_PASSIVE_SERIAL;
      bypass_en = 1'b0;
      in_byte = 8'h00;
      for (int i = 0; i < 4; i++) begin
         run_load(rows[i], 1'b0);
         $display("test row %0d done", i);
      end
      run_load('{chain_pkg::MODE_PASSIVE_SERIAL, 1'b0, 8'hF0, 1'b1}, 1'b1);
      $display("test stall done");
      // Reset in mid-load must leave the chain enable inactive
      do_reset();
      mode = chain_pkg::MODE_FAST_PARALLEL;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      send_byte(8'h11, 1'b0);
      send_byte(8'h22, 1'b0);
      do_reset();
      repeat (2) @(negedge clk);
      `CHECK({link.ceo_n, user_mode, busy}, 3'b100, "after abort")
      $display("test abort done");
      run_load('{chain_pkg::MODE_FAST_PARALLEL, 1'b0, 8'hC3, 1'b1}, 1'b0);
      $display("test recovery done");
      end_of_test();
   end

   // Six loads of a few hundred cycles each fit well inside this span
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("wrong value at %0t: %s", $time, "run timed out");
      end_of_test();
   end
endmodule
